// *** dv/icmap_periph_model.sv ***
/* Model of the peripherals and pins that feed the channel map.
   Assumes one request bit per channel from the bench. */
`timescale 1ns/1ps
`default_nettype none

module icmap_periph_model (
    // Requests by channel, pin inversion, watchdog control.
    input  wire logic [27:0] req,
    input  wire logic [7:0]  inv,
    input  wire logic        wdog_on,
    // Sources into the channel map.
    output logic [3:0]       timer_source,
    output logic [1:0]       serial_source,
    output logic [1:0]       dma_source,
    output logic             lock_lost_source,
    output logic             watchdog_source,
    output logic             clock_alarm_source,
    output logic             clock_periodic_source,
    output logic [3:0]       pwm_source,
    output logic             spi_source,
    output logic             display_ctrl_source,
    output logic [7:0]       ext_line
);
    // Each source follows its request; the watchdog obeys its own control.
    assign timer_source = req[3:0];
    assign serial_source = req[5:4];
    assign dma_source = req[7:6];
    assign lock_lost_source = req[8];
    assign watchdog_source = req[9] & wdog_on;
    assign clock_alarm_source = req[10];
    assign clock_periodic_source = req[11];
    assign pwm_source = req[15:12];
    assign spi_source = req[16];
    assign display_ctrl_source = req[18];
    // Active-low pins idle high, so the request is inverted there.
    assign ext_line = req[27:20] ^ inv;
endmodule // icmap_periph_model

`default_nettype wire

// *** dv/icmap_top_asserts.sv ***
/* Concurrent checks on the top ports of the channel map.
   Assumes the bind below and a single clock domain. */
`timescale 1ns/1ps
`default_nettype none

module icmap_top_asserts (
    // Clock and reset.
    input wire logic       clock,
    input wire logic       srst,
    // Bus and requests.
    input wire logic       hsel,
    input wire logic [1:0] htrans,
    input wire logic       hwrite,
    input wire logic       hready,
    input wire logic       hreadyout,
    input wire logic       hresp,
    input wire logic       watchdog_source,
    input wire logic       normal_request_out_n,
    input wire logic       fast_request_out_n,
    input wire logic       irq_out
);
    logic taken;
    logic wr_seen;

    default clocking @(posedge clock); endclocking
    default disable iff (srst);

    // A transfer is taken when selected, active and ready.
    assign taken = hsel && htrans[1] && hready;

    // Notes whether software has written anything since reset.
    always_ff @(posedge clock)
    begin
        if (srst)
            wr_seen <= 1'b0;
        else if (taken && hwrite)
            wr_seen <= 1'b1;
    end

    a_wdog_fast: assert property (
        $rose(watchdog_source) |-> ##2 !fast_request_out_n)
        else $error("Watchdog edge missed the fast request.");
    a_wdog_latch: assert property (
        (!hsel) [*2] ##0 $rose(watchdog_source) ##1 (!hsel) [*4] |=> !fast_request_out_n)
        else $error("Watchdog request dropped without a clear.");
    a_quiet_normal: assert property (
        !wr_seen |-> normal_request_out_n)
        else $error("Normal request with every source disabled.");
    a_quiet_irq: assert property (
        !wr_seen |-> !irq_out)
        else $error("Interrupt raised with events masked.");
    a_reset_idle: assert property (
        $fell(srst) |-> normal_request_out_n && fast_request_out_n && !irq_out)
        else $error("Outputs not idle after reset.");
    a_read_wait: assert property (
        taken && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("Read data phase not one wait state.");
    a_write_nowait: assert property (
        taken && hwrite |=> hreadyout)
        else $error("Write data phase stalled.");
    a_resp_okay: assert property (
        hresp == 1'b0)
        else $error("Response other than OKAY.");
endmodule // icmap_top_asserts

bind icmap_top icmap_top_asserts u_asserts (
    .clock, .srst, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp,
    .watchdog_source, .normal_request_out_n, .fast_request_out_n, .irq_out
);

`default_nettype wire

// *** dv/icmap_top_tb.sv ***
/* Self-checking bench for the interrupt channel map.
   Assumes the source model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none

module icmap_top_tb;
    import icmap_pkg::*;

    typedef struct {
        int         ch;
        logic       en;
        logic       rt;
        logic [1:0] ex;
        logic       lat;
    } icmap_row_t;

    logic        clock = 1'b0;
    logic        srst = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [27:0] req = 28'h000_0000;
    logic [7:0]  inv = 8'h00;
    logic        wdog_on = 1'b1;
    logic        hreadyout, hresp, irq_out;
    logic        normal_request_out_n, fast_request_out_n;
    logic [31:0] hrdata, d;
    logic [3:0]  timer_source, pwm_source;
    logic [1:0]  serial_source, dma_source;
    logic        lock_lost_source, watchdog_source, clock_alarm_source;
    logic        clock_periodic_source, spi_source, display_ctrl_source;
    logic [7:0]  ext_line;
    logic [1:0]  outs;
    int          miscompares = 0;
    int          n_compared = 0;
    // Channel, enable, route, outputs {normal, fast}, still set after drop.
    icmap_row_t  rows [11] = '{
        '{0, 1, 0, 2'b01, 0},
        '{5, 1, 1, 2'b10, 0},
        '{6, 0, 0, 2'b11, 0},
        '{8, 1, 0, 2'b01, 1},
        '{9, 0, 0, 2'b10, 1},
        '{11, 1, 1, 2'b10, 1},
        '{12, 1, 0, 2'b01, 1},
        '{16, 1, 1, 2'b10, 0},
        '{17, 1, 0, 2'b11, 0},
        '{18, 1, 0, 2'b01, 0},
        '{20, 1, 0, 2'b01, 0}
    };
    logic [7:0]  offs [4] = '{OFF_ENABLE, OFF_ROUTE, OFF_EXTCFG, OFF_EVMASK};
    logic [31:0] rvals [4] = '{32'h0000_0200, 32'h0000_0200, 32'h0000_FF00, 32'h0000_0000};

    assign outs = {normal_request_out_n, fast_request_out_n};

    icmap_periph_model u_model (
        .req, .inv, .wdog_on, .timer_source, .serial_source, .dma_source,
        .lock_lost_source, .watchdog_source, .clock_alarm_source,
        .clock_periodic_source, .pwm_source, .spi_source, .display_ctrl_source, .ext_line
    );

    icmap_top u_dut (
        .clock, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .timer_source, .serial_source,
        .dma_source, .lock_lost_source, .watchdog_source, .clock_alarm_source,
        .clock_periodic_source, .pwm_source, .spi_source, .display_ctrl_source,
        .ext_line_0(ext_line[0]), .ext_line_1(ext_line[1]), .ext_line_2(ext_line[2]),
        .ext_line_3(ext_line[3]), .ext_line_4(ext_line[4]), .ext_line_5(ext_line[5]),
        .ext_line_6(ext_line[6]), .ext_line_7(ext_line[7]), .normal_request_out_n,
        .fast_request_out_n, .irq_out
    );

    // Free-running system clock.
    initial
    begin
        forever #10 clock = ~clock;
    end

    // Compares one value and counts it.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic conclude();
        $display("Compared %0d, mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Lets n edges pass and steps clear of the last one.
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // Waits, bounded, until ready is seen, then passes that edge.
    task automatic ready_edge();
        int k;
        k = 0;
        @(negedge clock);
        while (hreadyout !== 1'b1 && k < 50)
        begin
            @(negedge clock);
            k++;
        end
        if (k == 50)
        begin
            miscompares++;
            conclude();
        end
        @(posedge clock);
    endtask

    // One single word transfer; read data lands in d.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h00_0000, a};
        ready_edge();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= v;
        ready_edge();
        #1;
        d = hrdata;
    endtask

    // Rows first, then the awkward cases and a reset in mid-run.
    initial
    begin
        icmap_row_t r;
        tick(6);
        srst <= 1'b0;
        tick(1);
        foreach (rows[i])
        begin
            r = rows[i];
            bus(1'b1, OFF_ENABLE, 32'(r.en) << r.ch);
            bus(1'b1, OFF_ROUTE, 32'(r.rt) << r.ch);
            req[r.ch] <= 1'b1;
            tick(6);
            chk(outs, r.ex);
            bus(1'b0, OFF_NSTAT, 32'h0000_0000);
            chk(d, 32'(!r.ex[1]) << r.ch);
            bus(1'b0, OFF_FSTAT, 32'h0000_0000);
            chk(d, 32'(!r.ex[0]) << r.ch);
            req[r.ch] <= 1'b0;
            tick(6);
            chk(outs, r.lat ? r.ex : 2'b11);
            bus(1'b1, OFF_CLEAR, 32'h0FFF_FFFF);
            tick(2);
            chk(outs, 2'b11);
        end
        wdog_on <= 1'b0;
        req[9] <= 1'b1;
        tick(4);
        chk(outs, 2'b11);
        req[9] <= 1'b0;
        wdog_on <= 1'b1;
        bus(1'b1, OFF_EXTCFG, 32'h0000_FD02);
        inv[1] <= 1'b1;
        tick(6);
        bus(1'b1, OFF_CLEAR, 32'h0FFF_FFFF);
        bus(1'b1, OFF_ENABLE, 32'h0020_0000);
        bus(1'b1, OFF_ROUTE, 32'h0020_0000);
        req[21] <= 1'b1;
        tick(3);
        req[21] <= 1'b0;
        tick(6);
        chk(outs, 2'b10);
        bus(1'b0, OFF_RAW, 32'h0000_0000);
        chk(d, 32'h0020_0000);
        bus(1'b1, OFF_ENABLE, 32'h0000_0001);
        bus(1'b0, OFF_EVT, 32'h0000_0000);
        req[0] <= 1'b1;
        tick(3);
        req[0] <= 1'b0;
        tick(3);
        chk(irq_out, 1'b0);
        bus(1'b1, OFF_EVMASK, 32'h0000_0003);
        tick(2);
        chk(irq_out, 1'b1);
        bus(1'b0, OFF_EVT, 32'h0000_0000);
        chk(d, 32'h0000_0001);
        tick(2);
        chk(irq_out, 1'b0);
        bus(1'b0, 8'h3C, 32'h0000_0000);
        chk(d, 32'h0000_0000);
        req[0] <= 1'b1;
        srst <= 1'b1;
        tick(2);
        chk(outs, 2'b11);
        srst <= 1'b0;
        req[0] <= 1'b0;
        tick(1);
        foreach (offs[i])
        begin
            bus(1'b0, offs[i], 32'h0000_0000);
            chk(d, rvals[i]);
        end
        bus(1'b1, OFF_ENABLE, 32'hFFFF_FFFF);
        bus(1'b0, OFF_ENABLE, 32'h0000_0000);
        chk(d, 32'h0FF5_FFFF);
        conclude();
    end
endmodule // icmap_top_tb

`default_nettype wire

// *** rtl/icmap_chan.sv ***
/*
 * One interrupt channel: edge capture with a pending latch, or a plain
 * level pass-through, chosen by is_edge.
 * Assumes src is already in the system clock domain with polarity applied.
 */
`timescale 1ns/1ps
`default_nettype none

module icmap_chan (
    // Clock and reset.
    input  wire logic clock,
    input  wire logic srst,
    // Source and configuration.
    input  wire logic src,
    input  wire logic is_edge,
    input  wire logic clear,
    // Request seen by the router.
    output logic      active
);

    logic src_prev;
    logic pending;

    // Rising edges latch until software clears; a new edge beats the clear.
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            src_prev <= 1'b0;
            pending  <= 1'b0;
        end
        else
        begin
            src_prev <= src;
            pending  <= (src & ~src_prev) | (pending & ~clear);
        end
    end

    // Level channels follow the source without latching.
    assign active = is_edge ? pending : src;

endmodule // icmap_chan

`default_nettype wire

// *** rtl/icmap_pkg.sv ***
/*
 * Shared constants of the interrupt channel map: register offsets, field
 * positions, reset values and the fixed channel layout.
 * Assumes a 32-bit AHB-Lite register bus decoded on the low address byte.
 */
package icmap_pkg;

    // Channel count and fixed channel positions.
    localparam int unsigned CH_COUNT = 28;
    localparam int unsigned CH_WDOG  = 9;
    localparam int unsigned CH_EXT0  = 20;
    localparam int unsigned EXT_COUNT = 8;
    localparam int unsigned EVT_COUNT = 2;

    // Channel class masks, one bit per channel.
    localparam logic [27:0] LEVEL_MASK    = 28'h005_00FF;
    localparam logic [27:0] EDGE_FIXED    = 28'h000_FF00;
    localparam logic [27:0] RESERVED_MASK = 28'h00A_0000;
    localparam logic [27:0] VALID_MASK    = 28'hFF5_FFFF;
    localparam logic [27:0] WDOG_MASK     = 28'h000_0200;

    // Register offsets on the low address byte.
    localparam logic [7:0] OFF_NSTAT  = 8'h00;
    localparam logic [7:0] OFF_FSTAT  = 8'h04;
    localparam logic [7:0] OFF_RAW    = 8'h08;
    localparam logic [7:0] OFF_ENABLE = 8'h0C;
    localparam logic [7:0] OFF_ROUTE  = 8'h10;
    localparam logic [7:0] OFF_EXTCFG = 8'h14;
    localparam logic [7:0] OFF_CLEAR  = 8'h18;
    localparam logic [7:0] OFF_EVT    = 8'h1C;
    localparam logic [7:0] OFF_EVMASK = 8'h20;

    // Field positions inside the external line configuration register.
    localparam int unsigned EXTCFG_EDGE_LSB = 0;
    localparam int unsigned EXTCFG_POL_LSB  = 8;

    // Event status bit positions.
    localparam int unsigned EVT_NORMAL = 0;
    localparam int unsigned EVT_FAST   = 1;

    // Reset values.
    localparam logic [27:0] RST_ENABLE = 28'h000_0000;
    localparam logic [27:0] RST_ROUTE  = 28'h000_0000;
    localparam logic [7:0]  RST_EDGE   = 8'h00;
    localparam logic [7:0]  RST_POL    = 8'hFF;
    localparam logic [1:0]  RST_EVMASK = 2'h0;

endpackage : icmap_pkg

// *** rtl/icmap_sync.sv ***
/*
 * Three-stage synchroniser for pin inputs, one chain per bit.
 * Assumes asynchronous inputs; the output changes only once stages two and
 * three agree, so a single-cycle glitch past stage one is not passed on.
 */
`timescale 1ns/1ps
`default_nettype none

module icmap_sync #(
    parameter int unsigned WIDTH = 8
) (
    // Clock and reset.
    input  wire logic             clock,
    input  wire logic             srst,
    // Raw pins and settled levels.
    input  wire logic [WIDTH-1:0] pin_in,
    output var  logic [WIDTH-1:0] level_out
);

    genvar b;

    // One chain per bit; stage one feeds stage two only.
    generate
        for (b = 0; b < WIDTH; b++)
        begin : g_bit
            logic st1;
            logic st2;
            logic st3;

            always_ff @(posedge clock)
            begin
                if (srst)
                begin
                    st1          <= 1'b0;
                    st2          <= 1'b0;
                    st3          <= 1'b0;
                    level_out[b] <= 1'b0;
                end
                else
                begin
                    st1 <= pin_in[b];
                    st2 <= st1;
                    st3 <= st2;
                    if (st2 == st3)
                    begin
                        level_out[b] <= st3;
                    end
                end
            end
        end
    endgenerate

endmodule // icmap_sync

`default_nettype wire

// *** rtl/icmap_top.sv ***
/*
 * Interrupt channel map: gathers 28 channels, applies trigger type and
 * polarity, masks them and routes them to the normal and fast request
 * outputs of the processor core. Registers sit on an AHB-Lite slave.
 * Assumes peripheral sources are on the system clock and external lines
 * come from pins. Only whole-word single transfers are expected.
 */
// Design decisions made here: the AHB-Lite register port and the register offsets.
// Summary of operation
// - Watchdog channel 9: edge, fast output only.
// - Watchdog unmaskable here; disable at source.
// - Channels 0-3 timers: high level, routable.
// - Channels 4-5 serial ports: high level, routable.
// - Channels 6-7 DMA: high level, routable.
// - Channel 8 lock lost: rising edge, routable.
// - Channels 10-11 clock alarm/periodic: rising edge.
// - Channels 12-15 modulators: rising edge, routable.
// - Channel 16 serial peripheral: high level, routable.
// - Channel 18 display controller: high level, routable.
// - Channels 20-27 external: routing, sense, polarity programmable.
// - Two active-low outputs: normal and fast request.
// - Per-source enable; masked sources assert nothing.
`timescale 1ns/1ps
`default_nettype none

module icmap_top
    import icmap_pkg::*;
(
    // Clock and reset.
    input  wire logic        clock,
    input  wire logic        srst,
    // AHB-Lite slave.
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // On-chip peripheral sources.
    input  wire logic [3:0]  timer_source,
    input  wire logic [1:0]  serial_source,
    input  wire logic [1:0]  dma_source,
    input  wire logic        lock_lost_source,
    input  wire logic        watchdog_source,
    input  wire logic        clock_alarm_source,
    input  wire logic        clock_periodic_source,
    input  wire logic [3:0]  pwm_source,
    input  wire logic        spi_source,
    input  wire logic        display_ctrl_source,
    // External interrupt pins.
    input  wire logic        ext_line_0,
    input  wire logic        ext_line_1,
    input  wire logic        ext_line_2,
    input  wire logic        ext_line_3,
    input  wire logic        ext_line_4,
    input  wire logic        ext_line_5,
    input  wire logic        ext_line_6,
    input  wire logic        ext_line_7,
    // Requests to the core and the summary interrupt.
    output logic             normal_request_out_n,
    output logic             fast_request_out_n,
    output logic             irq_out
);

    logic                 accept;
    logic                 wr_pend;
    logic                 rd_pend;
    logic [7:0]           addr_q;
    logic [7:0]           ext_level;
    logic [27:0]          src_raw;
    logic [27:0]          src_eff;
    logic [27:0]          edge_sel;
    logic [27:0]          clear_req;
    logic [27:0]          active;
    logic [27:0]          enable;
    logic [27:0]          route;
    logic [27:0]          en_eff;
    logic [27:0]          route_eff;
    logic [27:0]          norm_hit;
    logic [27:0]          fast_hit;
    logic [7:0]           ext_edge;
    logic [7:0]           ext_pol;
    logic [EVT_COUNT-1:0] evt_status;
    logic [EVT_COUNT-1:0] evt_mask;
    logic [EVT_COUNT-1:0] evt_set;
    logic [EVT_COUNT-1:0] evt_clr;
    logic [31:0]          rd_mux;
    logic                 wr_enable;
    logic                 wr_route;
    logic                 wr_extcfg;
    logic                 wr_clear;
    logic                 wr_evmask;

    // External pins pass the three-stage synchroniser.
    icmap_sync #(
        .WIDTH     (EXT_COUNT)
    ) u_sync (
        .clock     (clock),
        .srst      (srst),
        .pin_in    ({ext_line_7, ext_line_6, ext_line_5, ext_line_4,
                     ext_line_3, ext_line_2, ext_line_1, ext_line_0}),
        .level_out (ext_level)
    );

    // Channel layout; reserved slots are tied low.
    assign src_raw = {ext_level,
                      1'b0, display_ctrl_source,
                      1'b0, spi_source,
                      pwm_source,
                      clock_periodic_source, clock_alarm_source,
                      watchdog_source,
                      lock_lost_source,
                      dma_source,
                      serial_source,
                      timer_source};

    // External polarity: a clear bit means active low, so invert.
    assign src_eff = src_raw ^ {~ext_pol, 20'h0_0000};

    // Fixed edge channels, plus the external lines that select edge sense.
    assign edge_sel = (EDGE_FIXED | {ext_edge, 20'h0_0000}) & ~LEVEL_MASK;

    // Write-one-to-clear of latched edges.
    assign clear_req = (wr_clear ? hwdata[27:0] : 28'h000_0000);

    // One channel per slot; reserved slots never go active.
    genvar c;
    generate
        for (c = 0; c < CH_COUNT; c++)
        begin : g_ch
            if (RESERVED_MASK[c])
            begin : g_rsv
                assign active[c] = 1'b0;
            end
            else
            begin : g_used
                icmap_chan u_chan (
                    .clock   (clock),
                    .srst    (srst),
                    .src     (src_eff[c]),
                    .is_edge (edge_sel[c]),
                    .clear   (clear_req[c]),
                    .active  (active[c])
                );
            end
        end
    endgenerate

    // Watchdog is always enabled and always routed fast.
    assign en_eff    = (enable | WDOG_MASK) & VALID_MASK;
    assign route_eff = (route | WDOG_MASK) & VALID_MASK;
    assign norm_hit  = active & en_eff & ~route_eff;
    assign fast_hit  = active & en_eff & route_eff;

    // Address phase is taken when selected, non-idle and the bus is ready.
    assign accept    = hsel & htrans[1] & hready;
    assign wr_enable = wr_pend && (addr_q == OFF_ENABLE);
    assign wr_route  = wr_pend && (addr_q == OFF_ROUTE);
    assign wr_extcfg = wr_pend && (addr_q == OFF_EXTCFG);
    assign wr_clear  = wr_pend && (addr_q == OFF_CLEAR);
    assign wr_evmask = wr_pend && (addr_q == OFF_EVMASK);

    // Bus phase tracking; every read inserts one wait state.
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            wr_pend   <= 1'b0;
            rd_pend   <= 1'b0;
            addr_q    <= 8'h00;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            wr_pend   <= accept & hwrite;
            rd_pend   <= accept & ~hwrite;
            hreadyout <= ~(accept & ~hwrite);
            hresp     <= 1'b0;
            if (accept)
            begin
                addr_q <= haddr[7:0];
            end
        end
    end

    // Read data multiplexer; unmapped offsets read as zero.
    always_comb
    begin
        case (addr_q)
            OFF_NSTAT:  rd_mux = {4'h0, norm_hit};
            OFF_FSTAT:  rd_mux = {4'h0, fast_hit};
            OFF_RAW:    rd_mux = {4'h0, active};
            OFF_ENABLE: rd_mux = {4'h0, en_eff};
            OFF_ROUTE:  rd_mux = {4'h0, route_eff};
            OFF_EXTCFG: rd_mux = {16'h0000, ext_pol, ext_edge};
            OFF_EVT:    rd_mux = {30'h0000_0000, evt_status};
            OFF_EVMASK: rd_mux = {30'h0000_0000, evt_mask};
            default:    rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data is loaded at the end of the wait state.
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            hrdata <= 32'h0000_0000;
        end
        else if (rd_pend)
        begin
            hrdata <= rd_mux;
        end
    end

    // Per-channel enable and routing; the watchdog bit is not stored.
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            enable <= RST_ENABLE;
            route  <= RST_ROUTE;
        end
        else
        begin
            if (wr_enable)
            begin
                enable <= hwdata[27:0] & VALID_MASK & ~WDOG_MASK;
            end
            if (wr_route)
            begin
                route <= hwdata[27:0] & VALID_MASK & ~WDOG_MASK;
            end
        end
    end

    // External line sense and polarity.
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            ext_edge <= RST_EDGE;
            ext_pol  <= RST_POL;
        end
        else if (wr_extcfg)
        begin
            ext_edge <= hwdata[EXTCFG_EDGE_LSB +: EXT_COUNT];
            ext_pol  <= hwdata[EXTCFG_POL_LSB +: EXT_COUNT];
        end
    end

    // Request outputs, active low, straight from flops.
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            normal_request_out_n <= 1'b1;
            fast_request_out_n   <= 1'b1;
        end
        else
        begin
            normal_request_out_n <= ~(|norm_hit);
            fast_request_out_n   <= ~(|fast_hit);
        end
    end

    // Events: each request output going active; a read clears them.
    assign evt_set[EVT_NORMAL] = (|norm_hit) & normal_request_out_n;
    assign evt_set[EVT_FAST]   = (|fast_hit) & fast_request_out_n;
    assign evt_clr = (rd_pend && (addr_q == OFF_EVT)) ? {EVT_COUNT{1'b1}} : {EVT_COUNT{1'b0}};

    // Sticky event status; a new event wins over the read clear.
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            evt_status <= {EVT_COUNT{1'b0}};
            evt_mask   <= RST_EVMASK;
            irq_out    <= 1'b0;
        end
        else
        begin
            evt_status <= (evt_status & ~evt_clr) | evt_set;
            if (wr_evmask)
            begin
                evt_mask <= hwdata[EVT_COUNT-1:0];
            end
            irq_out <= |(evt_status & evt_mask);
        end
    end

endmodule // icmap_top

`default_nettype wire
